// ==== design/dbs_stack.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbs_stack
#(
	parameter int unsigned DEPTH = dbs_pkg::STACK_DEPTH
)
(
	// clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	// peripheral transfer from the core
	input  wire dbs_pkg::dbs_req_type        req,
	// answer to a get
	output dbs_pkg::dbs_rsp_type             rsp_q,
	// level pointer as seen in the register file
	output logic [dbs_pkg::LEVEL_W-1:0]      level_q
);
	import dbs_pkg::*;

	localparam int unsigned PTR_W = $clog2(DEPTH);

	////////////////////////////////////////////////////////////////////////
	// elaboration checks
	// the pointer wraps by plain overflow, so the depth must be a power of two;
	// it is read through the level field, so it may not be wider than that field
	if (DEPTH < 2 || DEPTH > 16)
	begin : g_bad_depth_range
		$error("dbs_stack: DEPTH must lie between 2 and 16");
	end

	if ((1 << PTR_W) != DEPTH)
	begin : g_bad_depth_pow2
		$error("dbs_stack: DEPTH must be a power of two");
	end

	if (PTR_W > LEVEL_W)
	begin : g_bad_level_w
		$error("dbs_stack: pointer does not fit the level field");
	end

	////////////////////////////////////////////////////////////////////////
	// shared decoding

	// one-hot select of the slot that a pointer value names
	function automatic logic [DEPTH-1:0] slot_sel(input logic [PTR_W-1:0] p);
		logic [DEPTH-1:0] s;
		s = '0;
		s[p] = 1'h1;
		return s;
	endfunction

	// an address class that takes a put
	function automatic logic writable(input dbs_access_type a);
		return (a == DBS_RW) || (a == DBS_WO);
	endfunction

	// an address class that gives data to a get
	function automatic logic readable(input dbs_access_type a);
		return (a == DBS_RW) || (a == DBS_RO);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// transfer decode
	dbs_access_type       access;
	logic                 is_stack;
	logic                 do_put;
	logic                 do_get;

	// pointer
	logic [PTR_W-1:0]     ptr_q;
	logic [PTR_W-1:0]     ptr_d;
	logic [PTR_W-1:0]     push_idx;
	logic [PTR_W-1:0]     pop_idx;

	// storage and its read path
	logic [WORD_W-1:0]    store_q [DEPTH];
	logic [DEPTH-1:0]     slot_wr;
	logic [DEPTH-1:0]     slot_rd;
	logic [WORD_W-1:0]    slot_term [DEPTH];
	logic [WORD_W-1:0]    pop_word;

	// answer
	logic                 rsp_valid_d;
	logic [WORD_W-1:0]    rsp_rdata_d;

	dbs_decode u_decode
	(
		.addr     (req.addr),
		.access   (access),
		.is_stack (is_stack)
	);

	// writes land only on writable addresses; anything else is dropped whole
	assign do_put = req.put && is_stack && writable(access);
	assign do_get = req.get && is_stack && readable(access);

	////////////////////////////////////////////////////////////////////////
	// level pointer
	// a put fills the slot under the pointer; a get pairs with the latest put,
	// one slot below, and from level zero wraps to the top with no flag
	assign push_idx = ptr_q;
	assign pop_idx  = ptr_q - PTR_W'(1);

	// put wins over a get in the same cycle; the get is still answered
	always_comb
	begin
		ptr_d = ptr_q;
		if (do_put)
			ptr_d = ptr_q + PTR_W'(1);
		else if (do_get)
			ptr_d = pop_idx;
	end

	// the stack does not count held levels: a fifth put silently replaces the
	// oldest word and a get past the bottom returns the wrapped slot, so the
	// software keeps its puts and gets paired
	// no write path exists, so software writes cannot reach the pointer
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			ptr_q <= PTR_W'(LEVEL_RST);
		else
			ptr_q <= ptr_d;
	end

	// the level field is wider than the pointer; its spare upper bits read zero
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			level_q <= LEVEL_W'(LEVEL_RST);
		else
			level_q <= LEVEL_W'(ptr_d);
	end

	////////////////////////////////////////////////////////////////////////
	// storage
	// no reset: contents are undefined until first saved, which keeps it small
	assign slot_wr = do_put ? slot_sel(push_idx) : '0;
	assign slot_rd = slot_sel(pop_idx);

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++)
		begin : g_slot
			// the slot under the pointer is overwritten, even if still held
			always_ff @(posedge ref_clk)
			begin
				if (slot_wr[g])
					store_q[g] <= req.wdata;
			end

			// and-or read: an unselected slot adds nothing, so an unwritten
			// slot cannot spoil the word of another
			assign slot_term[g] = slot_rd[g] ? store_q[g] : '0;
		end
	endgenerate

	always_comb
	begin
		pop_word = '0;
		for (int i = 0; i < DEPTH; i++)
			pop_word = pop_word | slot_term[i];
	end

	////////////////////////////////////////////////////////////////////////
	// answer to a get
	// every get is answered one cycle later, wherever it points; only the stack
	// port has data behind it, every other address gives a fixed filler
	always_comb
	begin
		rsp_valid_d = req.get;
		rsp_rdata_d = UNDEF_READ;
		if (do_get)
			rsp_rdata_d = pop_word;
	end

	// data stands until the next get, so the core may take it late
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rsp_q.valid <= 1'h0;
			rsp_q.rdata <= '0;
		end
		else
		begin
			rsp_q.valid <= rsp_valid_d;
			if (rsp_valid_d)
				rsp_q.rdata <= rsp_rdata_d;
		end
	end
endmodule // dbs_stack
`default_nettype wire

// ==== design/dbs_pkg.sv ====
`default_nettype none
package dbs_pkg;
	localparam int unsigned PADDR_W = 7;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned STACK_DEPTH = 4;
	localparam int unsigned LEVEL_W = 4;
	localparam logic [PADDR_W-1:0] STACK_PORT_ADDR = 7'h41;
	// level pointer sits in the register file space, not the peripheral space
	localparam logic [6:0] LEVEL_RF_ADDR = 7'h04;
	localparam logic [1:0] LEVEL_RST = 2'h0;
	localparam logic [WORD_W-1:0] UNDEF_READ = 16'h0000;

	typedef enum logic [1:0] {
		DBS_UNUSED = 2'h0,
		DBS_RO     = 2'h1,
		DBS_RW     = 2'h3,
		DBS_WO     = 2'h2
	} dbs_access_type;

	typedef struct packed {
		logic [PADDR_W-1:0] addr;
		logic               put;
		logic               get;
		logic [WORD_W-1:0]  wdata;
	} dbs_req_type;

	typedef struct packed {
		logic              valid;
		logic [WORD_W-1:0] rdata;
	} dbs_rsp_type;
endpackage
`default_nettype wire

// ==== design/dbs_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbs_decode
(
	// address in
	input  wire logic [dbs_pkg::PADDR_W-1:0] addr,
	// class out
	output dbs_pkg::dbs_access_type          access,
	output logic                             is_stack
);
	import dbs_pkg::*;

	function automatic dbs_access_type classify(input logic [PADDR_W-1:0] a);
		// only the save stack port is served here; other peripherals decode elsewhere
		if (a == STACK_PORT_ADDR)
			return DBS_RW;
		else
			return DBS_UNUSED;
	endfunction

	assign access = classify(addr);
	assign is_stack = (addr == STACK_PORT_ADDR);
endmodule // dbs_decode
`default_nettype wire

// ==== verif/dbs_stack_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbs_stack_asserts
(
	// clock and reset
	input wire logic                   ref_clk,
	input wire logic                   nrst,
	// watched ports
	input wire dbs_pkg::dbs_req_type   req,
	input wire dbs_pkg::dbs_rsp_type   rsp_q,
	input wire logic [3:0]             level_q
);
	import dbs_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire logic hit = req.addr == STACK_PORT_ADDR;
	sequence s_put; req.put && hit; endsequence
	sequence s_pop; req.get && !req.put && hit; endsequence
	chk_get_answer: assert property (req.get |=> rsp_q.valid) else $error("no answer");
	chk_no_stray: assert property (!req.get |=> !rsp_q.valid) else $error("stray answer");
	chk_put_step: assert property (s_put |=> level_q[1:0] == $past(level_q[1:0]) + 2'h1)
		else $error("put step");
	chk_pop_step: assert property (s_pop |=> level_q[1:0] == $past(level_q[1:0]) - 2'h1)
		else $error("get step");
	chk_upper_zero: assert property (level_q[3:2] == 2'h0) else $error("upper bits");
	chk_level_keep: assert property (!(hit && (req.put || req.get)) |=> $stable(level_q))
		else $error("level moved");
	chk_undef_read: assert property (req.get && !hit |=> rsp_q.rdata == UNDEF_READ)
		else $error("undefined read");
	chk_data_keep: assert property (!req.get |=> $stable(rsp_q.rdata)) else $error("data moved");
endmodule // dbs_stack_asserts
bind dbs_stack dbs_stack_asserts u_chk (.ref_clk, .nrst, .req, .rsp_q, .level_q);
`default_nettype wire

// ==== verif/dbs_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbs_core
(
	// clock
	input  wire logic                ref_clk,
	// transfer to the block
	output var dbs_pkg::dbs_req_type req
);
	import dbs_pkg::*;
	initial req = '0;
	// data flips after the strobe so a stale word never looks valid
	task automatic xfer(input logic [6:0] a, input logic p, g, input logic [15:0] d);
		@(posedge ref_clk);
		req <= '{a, p, g, d};
		@(posedge ref_clk);
		req <= '{a, 1'h0, 1'h0, ~d};
	endtask
endmodule // dbs_core
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dbs_pkg::*;
	logic        ref_clk = 1'h0;
	logic        nrst = 1'h0;
	dbs_req_type req;
	dbs_rsp_type rsp_q;
	logic [3:0]  level_q;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;
	initial forever #2.5 ref_clk = ~ref_clk;
	dbs_core u_core (.ref_clk, .req);
	dbs_stack u_dut (.ref_clk, .nrst, .req, .rsp_q, .level_q);
	task automatic conclude;
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic op(input logic [6:0] a, input logic p, g, input logic [15:0] d, lv, rd);
		u_core.xfer(a, p, g, d);
		#1 chk(16'(level_q), lv);
		if (g)
		begin
			chk(16'(rsp_q.valid), 16'h1);
			chk(rsp_q.rdata, rd);
		end
		else
			chk(16'(rsp_q.valid), 16'h0);
	endtask
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 400)
		begin
			error_cnt++;
			conclude;
		end
	end
	initial
	begin
		repeat (6) @(posedge ref_clk);
		nrst <= 1'h1;
		#1 chk(16'(level_q), 16'h0);
		op(7'h41, 1'h1, 1'h0, 16'ha5c3, 16'h1, 16'h0);
		op(7'h41, 1'h1, 1'h0, 16'h3c5a, 16'h2, 16'h0);
		op(7'h41, 1'h1, 1'h0, 16'hf00f, 16'h3, 16'h0);
		op(7'h41, 1'h1, 1'h0, 16'h0ff0, 16'h0, 16'h0);
		op(7'h41, 1'h1, 1'h0, 16'h8001, 16'h1, 16'h0);
		op(7'h41, 1'h0, 1'h1, 16'h0, 16'h0, 16'h8001);
		op(7'h41, 1'h0, 1'h1, 16'h0, 16'h3, 16'h0ff0);
		op(7'h41, 1'h0, 1'h1, 16'h0, 16'h2, 16'hf00f);
		op(7'h40, 1'h1, 1'h0, 16'hffff, 16'h2, 16'h0);
		op(7'h42, 1'h0, 1'h1, 16'h0, 16'h2, UNDEF_READ);
		op(7'h41, 1'h0, 1'h1, 16'h0, 16'h1, 16'h3c5a);
		op(7'h41, 1'h1, 1'h1, 16'h1234, 16'h2, 16'h8001);
		op(7'h41, 1'h0, 1'h1, 16'h0, 16'h1, 16'h1234);
		@(posedge ref_clk);
		nrst <= 1'h0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'h1;
		#1 chk(16'(level_q), 16'h0);
		op(7'h41, 1'h0, 1'h1, 16'h0, 16'h3, 16'h0ff0);
		conclude;
	end
endmodule // tb
`default_nettype wire
